// file: bench/sadc_analog_model.sv
`timescale 1ns/10ps
// ==========================================================
// Analog front end: sample-hold, tap ladder and comparator
// ==========================================================
module sadc_analog_model (
    input  wire logic             clk,
    input  wire logic [7:0][15:0] vin,
    input  wire logic             sample_hold,
    input  wire logic [7:0]       tap_sel,
    input  wire logic [2:0]       chan_sel,
    input  wire logic             ladder_en,
    output logic                  comp_in
);
    logic [15:0] held_q = 16'h0000;
    logic        junk_q = 1'b0;

    // Track only the selected input while sampling, freeze on hold
    always @(posedge clk) begin
        junk_q <= ~junk_q;
        if (sample_hold) begin
            held_q <= vin[chan_sel];
        end
    end

    // Taps sit half a step low, so the search lands on rounded codes
    always_comb begin
        if (ladder_en) begin
            comp_in = {1'b0, held_q}
                      > ({1'b0, tap_sel, 8'h00} - 17'h80);
        end else begin
            comp_in = junk_q; // Ladder off: output is meaningless
        end
    end
endmodule

// file: bench/tb.sv
`timescale 1ns/10ps
module tb;
    import sadc_pkg::*;
    logic             REF_CLK = 1'b0;
    logic             RESETN  = 1'b0;
    logic [7:0]       ADDR    = 8'h00;
    logic [7:0]       WDATA   = 8'h00;
    logic             WR      = 1'b0;
    logic             RD      = 1'b0;
    logic             STANDBY = 1'b0;
    logic [7:0]       RDATA;
    logic             COMP_IN;
    logic             SAMPLE_HOLD;
    logic             LADDER_EN;
    logic             CONV_DONE_IRQ;
    logic             CONV_DONE_FLAG;
    logic [7:0]       TAP_SEL;
    logic [2:0]       CHAN_SEL;
    logic [7:0][15:0] vin = '0;
    logic             sh_prev = 1'b0;
    int               num_errors = 0;
    int               num_checks = 0;
    int               n;
    int               sh;
    logic [7:0]       d;
    logic [2:0]       ch;
    logic [2:0]       codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    int               lens  [6] = '{CLKS_144, CLKS_120, CLKS_96,
                                    CLKS_72, CLKS_60, CLKS_48};
    logic [7:0]       ra    [4] = '{OFF_MODE, OFF_CHAN, OFF_STATUS, 8'h84};
    localparam int    N = CLKS_48;

    always #50 REF_CLK = ~REF_CLK;

    sadc_top i_sadc_top (.REF_CLK(REF_CLK), .RESETN(RESETN), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .COMP_IN(COMP_IN),
        .STANDBY(STANDBY), .SAMPLE_HOLD(SAMPLE_HOLD), .TAP_SEL(TAP_SEL),
        .CHAN_SEL(CHAN_SEL), .LADDER_EN(LADDER_EN),
        .CONV_DONE_IRQ(CONV_DONE_IRQ), .CONV_DONE_FLAG(CONV_DONE_FLAG));

    sadc_analog_model i_sadc_analog_model (.clk(REF_CLK), .vin(vin),
        .sample_hold(SAMPLE_HOLD), .tap_sel(TAP_SEL), .chan_sel(CHAN_SEL),
        .ladder_en(LADDER_EN), .comp_in(COMP_IN));

    // ==========================================================
    // Compare, bus and wait tasks
    // ==========================================================
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Cycle counts are bench-side numbers, checked against a window
    task automatic chk_rng(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge REF_CLK);
        WR    <= 1'b1;
        ADDR  <= a;
        WDATA <= v;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge REF_CLK);
        RD   <= 1'b1;
        ADDR <= a;
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1 v = RDATA;
    endtask

    // Counts cycles, and sample cycles, up to the next done pulse
    task automatic wait_irq(output int cnt, output int shc);
        cnt = 0;
        shc = 0;
        do begin
            @(posedge REF_CLK);
            #1 cnt++;
            if (SAMPLE_HOLD === 1'b1) shc++;
        end while (CONV_DONE_IRQ !== 1'b1 && cnt < 1000);
        if (cnt >= 1000) begin
            num_errors++;
            give_verdict();
        end
    endtask

    // Nothing may run: no pulse and no sampling
    task automatic quiet(input int cycles);
        int busy;
        busy = 0;
        repeat (cycles) begin
            @(posedge REF_CLK);
            #1 if (CONV_DONE_IRQ !== 1'b0 || SAMPLE_HOLD !== 1'b0) busy++;
        end
        chk_rng(busy, 0, 0);
    endtask

    function automatic logic [7:0] code_of(input logic [15:0] v);
        logic [16:0] s;
        s = {1'b0, v} + 17'h80;
        return s[16] ? 8'hff : s[15:8];
    endfunction

    // Exact half-step ties are avoided, rounding there is ambiguous
    function automatic logic [15:0] rnd_v();
        logic [15:0] v;
        v = 16'($urandom);
        if (v[7:0] == 8'h80) v[0] = 1'b1;
        return v;
    endfunction

    // First hold cycle must present the half-scale tap
    always @(negedge REF_CLK) begin
        if (sh_prev && SAMPLE_HOLD === 1'b0 && LADDER_EN === 1'b1) begin
            chk8(TAP_SEL, SAR_MSB);
        end
        sh_prev = SAMPLE_HOLD;
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        void'($urandom(19));
        repeat (8) @(posedge REF_CLK);
        RESETN <= 1'b1;
        // Result left out: undefined until a conversion ends
        foreach (ra[i]) begin
            rd(ra[i], d);
            chk8(d, 8'h00);
        end
        quiet(300);
        $display("test reset done");

        // Six time codes, one per length, corner voltages at both ends
        for (int i = 0; i < 6; i++) begin
            ch = 3'($urandom);
            for (int j = 0; j < 8; j++) vin[j] = rnd_v();
            if (i == 0) vin[ch] = 16'h0000;
            if (i == 5) vin[ch] = 16'hffff;
            wr(OFF_STATUS, 8'h01);
            wr(OFF_CHAN, {5'h00, ch});
            wr(OFF_MODE, {2'b10, codes[i], 3'h0});
            wait_irq(n, sh);
            chk_rng(n, lens[i] - 1, lens[i] + 2);
            wait_irq(n, sh);
            chk_rng(n, lens[i], lens[i]);
            chk_rng(sh, lens[i] / 3, lens[i] / 3);
            chk8({7'h00, CONV_DONE_FLAG}, 8'h01);
            chk8({5'h00, CHAN_SEL}, {5'h00, ch});
            rd(OFF_RESULT, d);
            chk8(d, code_of(vin[ch]));
            rd(OFF_MODE, d);
            chk8(d, {2'b10, codes[i], 3'h0});
        end
        $display("test time codes done");

        // Channel write mid-conversion, prohibited high bit set
        wait_irq(n, sh);
        repeat (20) @(posedge REF_CLK);
        vin[3] <= 16'h5a17;
        wr(OFF_CHAN, 8'h0b);
        #1 chk8({7'h00, CONV_DONE_FLAG}, 8'h01);
        chk8({5'h00, CHAN_SEL}, 8'h03);
        rd(OFF_STATUS, d);
        chk8(d & 8'h02, 8'h02);
        wait_irq(n, sh);
        chk_rng(n, N - 3, N);
        rd(OFF_RESULT, d);
        chk8(d, code_of(16'h5a17));
        $display("test abort done");

        // Read on the completion edge sees the old value first
        wait_irq(n, sh);
        vin[3] = 16'h2345;
        repeat (N - 2) @(posedge REF_CLK);
        rd(OFF_RESULT, d);
        chk8(d, code_of(16'h5a17));
        rd(OFF_RESULT, d);
        chk8(d, code_of(16'h2345));

        // Control write on the completion edge wins
        wait_irq(n, sh);
        vin[3] = 16'h7f00;
        repeat (N - 2) @(posedge REF_CLK);
        wr(OFF_CHAN, 8'h05);
        #1 chk8({7'h00, CONV_DONE_IRQ}, 8'h00);
        rd(OFF_RESULT, d);
        chk8(d, code_of(16'h2345));
        wait_irq(n, sh);
        chk_rng(n, N - 3, N);
        rd(OFF_RESULT, d);
        chk8(d, code_of(vin[5]));
        $display("test conflicts done");

        // Standby freezes for exactly its length, no abort
        wait_irq(n, sh);
        repeat (10) @(posedge REF_CLK);
        STANDBY <= 1'b1;
        repeat (50) @(posedge REF_CLK);
        STANDBY <= 1'b0;
        wait_irq(n, sh);
        chk_rng(n, N - 11, N - 9);
        $display("test standby done");

        // Enable cleared mid-conversion stops at once
        repeat (15) @(posedge REF_CLK);
        wr(OFF_MODE, 8'h30);
        @(posedge REF_CLK);
        #1 chk8({6'h00, SAMPLE_HOLD, LADDER_EN}, 8'h00);
        chk8({7'h00, CONV_DONE_FLAG}, 8'h01);
        wr(OFF_STATUS, 8'h01);
        rd(OFF_STATUS, d);
        chk8(d, 8'h00);
        quiet(300);
        $display("test stop done");
        give_verdict();
    end
endmodule

// file: hw/sadc_pkg.sv
package sadc_pkg;

    // ==========================================================
    // Register map (byte offsets on the plain register port)
    // ==========================================================
    localparam logic [7:0] OFF_MODE   = 8'h80;
    localparam logic [7:0] OFF_CHAN   = 8'h81;
    localparam logic [7:0] OFF_RESULT = 8'h82;
    localparam logic [7:0] OFF_STATUS = 8'h83;

    // Field positions and reset values
    localparam int         MODE_EN_BIT   = 7;
    localparam int         MODE_TSEL_LSB = 3;
    localparam int         STAT_FLAG_BIT = 0;
    localparam int         STAT_BUSY_BIT = 1;
    localparam logic [7:0] MODE_RST      = 8'h00;
    localparam logic [3:0] CHAN_RST      = 4'h0;
    localparam logic [7:0] RESULT_RST    = 8'h00;

    // ==========================================================
    // Timing: conversion split into 12 equal units
    // ==========================================================
    localparam int         CONV_UNITS   = 12;
    localparam int         SAMPLE_UNITS = 4;
    localparam logic [3:0] SAMPLE_LAST  = 4'(SAMPLE_UNITS - 1);
    localparam logic [3:0] LAST_UNIT    = 4'(CONV_UNITS - 1);
    localparam int         CLKS_144     = 144;
    localparam int         CLKS_120     = 120;
    localparam int         CLKS_96      = 96;
    localparam int         CLKS_72      = 72;
    localparam int         CLKS_60      = 60;
    localparam int         CLKS_48      = 48;
    localparam logic [7:0] SAR_MSB      = 8'h80;

    typedef enum logic [0:0] {
        SADC_IDLE = 1'b0,
        SADC_CONV = 1'b1
    } sadc_mode_t;

    typedef struct packed {
        logic       load;
        logic       step;
        logic [2:0] bitn;
        logic       comp;
    } sadc_sar_ctl_t;

    typedef struct packed {
        sadc_mode_t mode;
        logic [3:0] unit;
        logic       en;
        logic [2:0] tsel;
        logic [3:0] chan;
        logic [7:0] result;
        logic       flag;
        logic       irq;
        logic [7:0] rdata;
        logic       sample;
    } sadc_state_t;

    // Clocks per unit for a conversion-time code
    function automatic logic [3:0] sadc_unit_len(
        input logic [2:0] tsel);
        case (tsel)
            3'h1:    return 4'(CLKS_120 / CONV_UNITS);
            3'h2:    return 4'(CLKS_96 / CONV_UNITS);
            3'h4:    return 4'(CLKS_72 / CONV_UNITS);
            3'h5:    return 4'(CLKS_60 / CONV_UNITS);
            3'h6:    return 4'(CLKS_48 / CONV_UNITS);
            default: return 4'(CLKS_144 / CONV_UNITS);
        endcase
    endfunction

    // Resolve trial bit b from comparator, trial-set next bit
    function automatic logic [7:0] sadc_resolve(
        input logic [7:0] v,
        input logic [2:0] b,
        input logic       c);
        logic [7:0] r;
        r    = v;
        r[b] = c;
        if (b != 3'h0) begin
            r[b - 3'h1] = 1'b1;
        end
        return r;
    endfunction

endpackage

// file: hw/sadc_sar.sv
`timescale 1ns/10ps
module sadc_sar
    import sadc_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  sadc_sar_ctl_t      ctl,
    output logic         [7:0] q
);
    // ==========================================================
    // Approximation register
    // ==========================================================
    logic [7:0] q_d;

    // Load trial MSB, then one resolve per bit unit
    always_comb begin
        q_d = q;
        if (ctl.load) begin
            q_d = SAR_MSB; // R3
        end else if (ctl.step) begin
            q_d = sadc_resolve(q, ctl.bitn, ctl.comp); // R4 R5 R6
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= 8'h00;
        end else begin
            q <= q_d;
        end
    end

endmodule

// file: hw/sadc_tick.sv
`timescale 1ns/10ps
module sadc_tick
    import sadc_pkg::*;
#(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         en,
    input  wire logic         clr,
    input  wire logic [W-1:0] len,
    output logic              tick
);
    // ==========================================================
    // Unit divider: one-cycle enable every len clocks
    // ==========================================================
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // Not gated by clr: a write on the last unit must still see the due end
    assign tick = en && (cnt_q == len - W'(1));

    // Clear wins so a restart always gets a full first unit
    always_comb begin
        cnt_d = cnt_q;
        if (clr) begin
            cnt_d = '0;
        end else if (tick) begin
            cnt_d = '0;
        end else if (en) begin
            cnt_d = cnt_q + W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

// file: hw/sadc_top.sv
// Function
// R1: Software selects one of eight inputs
// R2: Sample fixed time, then hold until done
// R3: After sampling set MSB, tap at half
// R4: Keep MSB if input above tap
// R5: Trial bit 6 at three or one quarter
// R6: Same procedure down to bit 0
// R7: Latch result and raise irq together
// R8: Restart at once while enabled
// R9: Mode or channel write aborts, restarts
// R10: Writing enable zero stops immediately
// R11: Only software enable write starts conversion
// R12: Result is rounded ratiometric 8-bit code
// R13: Result undefined until first conversion
// R14: Coincident read returns old result first
// R15: Coincident control write suppresses result, irq
// R16: External trigger ignored during conversion
// R17: Channel write keeps done flag
// R18: Software clears flag before re-enabling
// R19: Standby halts sequencer
// R20: Avoid digital read of analog pin
// R21: Time code selects total conversion clocks
// R22: Low three channel bits select input
// R23: Enable is mode bit 7, reset zero
// R24: Result invalid right after enabling
// R25: Clock counter times whole conversion
// R26: Done flag sticky until software clears
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module sadc_top
    import sadc_pkg::*;
(
    input  wire logic       REF_CLK,
    input  wire logic       RESETN,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       COMP_IN,
    input  wire logic       STANDBY,
    output logic            SAMPLE_HOLD,
    output logic      [7:0] TAP_SEL,
    output logic      [2:0] CHAN_SEL,
    output logic            LADDER_EN,
    output logic            CONV_DONE_IRQ,
    output logic            CONV_DONE_FLAG
);
    // ==========================================================
    // State and decode
    // ==========================================================
    sadc_state_t   st_q;
    sadc_state_t   st_d;
    sadc_sar_ctl_t sar_ctl;
    logic [7:0]    sar_q;
    logic          tick;
    logic          tick_clr;
    logic          wr_mode;
    logic          wr_chan;
    logic          wr_stat;
    logic          busy;
    logic          run;
    logic          last_tick;
    logic          done_ok;
    logic          ctl_wr;

    assign wr_mode   = WR && (ADDR == OFF_MODE);
    assign wr_chan   = WR && (ADDR == OFF_CHAN);
    assign wr_stat   = WR && (ADDR == OFF_STATUS);
    assign busy      = (st_q.mode == SADC_CONV);
    // Standby freezes the unit divider, unit count and SAR mid-conversion
    assign run       = busy && !STANDBY; // R19
    assign last_tick = tick && (st_q.unit == LAST_UNIT);
    // Mode or channel write: aborts whatever unit is due
    assign ctl_wr    = wr_mode || wr_chan;
    // A control write in the last cycle beats the result
    assign done_ok   = last_tick && !ctl_wr; // R15

    // ==========================================================
    // Unit divider and approximation register
    // ==========================================================
    sadc_tick #(
        .W     (4)
    ) u_tick (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .en    (run),
        .clr   (tick_clr),
        .len   (sadc_unit_len(st_q.tsel)), // R21 R25
        .tick  (tick)
    );

    sadc_sar u_sar (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .ctl   (sar_ctl),
        .q     (sar_q)
    );

    // Drive the approximation register from the unit count
    always_comb begin
        // An aborting write must not step a conversion it cancels
        sar_ctl.load = tick && !ctl_wr && (st_q.unit == SAMPLE_LAST); // R3
        sar_ctl.step = tick && !ctl_wr && (st_q.unit > SAMPLE_LAST); // R6
        sar_ctl.bitn = 3'(LAST_UNIT - st_q.unit);
        sar_ctl.comp = COMP_IN; // R4 R5
    end

    // ==========================================================
    // Sequencer and register file
    // ==========================================================
    always_comb begin
        st_d       = st_q;
        st_d.irq   = 1'b0;
        st_d.rdata = 8'h00;
        tick_clr   = 1'b0;

        // Count units; the sample phase ends into hold
        if (tick) begin
            st_d.unit = st_q.unit + 4'h1;
            if (st_q.unit == SAMPLE_LAST) begin
                st_d.sample = 1'b0; // R2
            end
        end

        // End of conversion: latch, flag, go again
        if (last_tick) begin
            st_d.unit   = 4'h0;
            st_d.sample = 1'b1; // R8
            tick_clr    = 1'b1;
        end
        if (done_ok) begin
            // Final bit resolved straight from the comparator
            st_d.result = {sar_q[7:1], COMP_IN}; // R7 R12
            st_d.flag   = 1'b1; // R26
            st_d.irq    = 1'b1; // R7
        end

        // Status write clears the flag unless a set coincides
        if (wr_stat && WDATA[STAT_FLAG_BIT] && !done_ok) begin
            st_d.flag = 1'b0; // R26
        end

        // Channel write: new input, flag untouched
        if (wr_chan) begin
            st_d.chan = WDATA[3:0]; // R22 R17
        end

        // Mode write: time code and enable
        if (wr_mode) begin
            st_d.en   = WDATA[MODE_EN_BIT]; // R23
            st_d.tsel = WDATA[MODE_TSEL_LSB +: 3]; // R21
        end

        // Any control write restarts or stops the sequence
        if (wr_mode || wr_chan) begin
            tick_clr    = 1'b1;
            st_d.unit   = 4'h0;
            st_d.sample = 1'b1;
            if (wr_mode) begin
                // Only software enable starts; no trigger input
                st_d.mode = WDATA[MODE_EN_BIT] ? SADC_CONV
                                               : SADC_IDLE; // R10 R11 R16
            end else begin
                st_d.mode = st_q.en ? SADC_CONV : SADC_IDLE; // R9
            end
            if (st_d.mode == SADC_IDLE) begin
                st_d.sample = 1'b0;
            end
        end

        // Read data from the old state, so a read beside
        // completion sees the previous result
        if (RD) begin
            unique case (ADDR)
                OFF_MODE:   st_d.rdata = {st_q.en, 1'b0, st_q.tsel,
                                          3'h0};
                OFF_CHAN:   st_d.rdata = {4'h0, st_q.chan};
                OFF_RESULT: st_d.rdata = st_q.result; // R14
                OFF_STATUS: st_d.rdata = {6'h00, busy, st_q.flag};
                default:    st_d.rdata = 8'h00;
            endcase
        end
    end

    // Single register stage for the whole state
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_q        <= '0;
            st_q.mode   <= SADC_IDLE;
            st_q.en     <= MODE_RST[MODE_EN_BIT]; // R23
            st_q.tsel   <= MODE_RST[MODE_TSEL_LSB +: 3];
            st_q.chan   <= CHAN_RST;
            st_q.result <= RESULT_RST; // R13
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign RDATA          = st_q.rdata;
    assign SAMPLE_HOLD    = st_q.sample;
    assign TAP_SEL        = sar_q; // R3 R5
    assign CHAN_SEL       = st_q.chan[2:0]; // R1
    assign LADDER_EN      = st_q.en; // R19
    assign CONV_DONE_IRQ  = st_q.irq;
    assign CONV_DONE_FLAG = st_q.flag;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESETN);

    // Cycle counter inside one conversion, for timing checks
    logic [7:0] conv_clks_q;
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            conv_clks_q <= 8'h00;
        end else if (tick_clr || !busy) begin
            conv_clks_q <= 8'h00;
        end else if (run) begin
            conv_clks_q <= conv_clks_q + 8'h01;
        end
    end

    a_done_period:                                     // R25
    assert property (done_ok |->
        conv_clks_q == 8'(16'(sadc_unit_len(st_q.tsel))
                         * 16'(CONV_UNITS) - 16'h1))
        else $error("conversion length wrong");

    a_irq_result:                                      // R7
    assert property (done_ok |=>
        CONV_DONE_IRQ && CONV_DONE_FLAG && st_q.result == TAP_SEL)
        else $error("result and irq not together");

    a_irq_only_done:                                   // R15
    assert property (CONV_DONE_IRQ |-> $past(done_ok))
        else $error("irq without clean completion");

    a_ctl_blocks:                                      // R15
    assert property (last_tick && (wr_mode || wr_chan) |=>
        !CONV_DONE_IRQ && $stable(st_q.result))
        else $error("write did not suppress result");

    a_msb_trial:                                       // R3
    assert property (sar_ctl.load |=>
        TAP_SEL == SAR_MSB && !SAMPLE_HOLD)
        else $error("msb trial not set after sample");

    a_hold_kept:                                       // R2
    assert property (busy && !SAMPLE_HOLD && !tick_clr |=>
        !SAMPLE_HOLD)
        else $error("hold released mid conversion");

    a_keep_clear:                                      // R4
    assert property (sar_ctl.step && !COMP_IN |=>
        TAP_SEL[$past(sar_ctl.bitn)] == 1'b0)
        else $error("trial bit not cleared");

    a_stop_now:                                        // R10
    assert property (wr_mode && !WDATA[MODE_EN_BIT] |=>
        !busy ##1 !busy && !CONV_DONE_IRQ)
        else $error("conversion not stopped");

    a_sw_start:                                        // R11
    assert property (!busy ##1 busy |-> $past(wr_mode)
        && $past(WDATA[MODE_EN_BIT]))
        else $error("start without enable write");

    a_abort_restart:                                   // R9
    assert property (wr_chan && st_q.en |=>
        busy && SAMPLE_HOLD && st_q.unit == 4'h0)
        else $error("channel write did not restart");

    a_flag_kept:                                       // R17
    assert property (CONV_DONE_FLAG && wr_chan && !wr_stat |=>
        CONV_DONE_FLAG)
        else $error("channel write cleared flag");

    a_read_old:                                        // R14
    assert property (RD && ADDR == OFF_RESULT |=>
        RDATA == $past(st_q.result))
        else $error("read did not return old result");

    a_standby_halt:                                    // R19
    assert property (STANDBY && busy |=> $stable(st_q.unit)
        && $stable(TAP_SEL))
        else $error("sequencer moved in standby");

    a_bit_keep:                                        // R4
    assert property (sar_ctl.step && COMP_IN |=>
        TAP_SEL[$past(sar_ctl.bitn)] == 1'b1)
        else $error("trial bit not kept");

    a_restart_now:                                     // R8
    assert property (done_ok |=>
        busy && SAMPLE_HOLD && st_q.unit == 4'h0)
        else $error("next conversion not started");

    a_chan_low:                                        // R22
    assert property (wr_chan |=>
        CHAN_SEL == 3'($past(WDATA)))
        else $error("channel select not from low bits");

    a_flag_sticky:                                     // R26
    assert property (CONV_DONE_FLAG && !(wr_stat && WDATA[STAT_FLAG_BIT])
        |=> CONV_DONE_FLAG)
        else $error("done flag dropped without clear");

    c_completion:
    cover property (done_ok ##1 CONV_DONE_IRQ);

    c_back_to_back:
    cover property (done_ok ##[1:200] done_ok);

    c_abort:
    cover property (busy && wr_chan && st_q.unit > SAMPLE_LAST);

    c_read_clash:
    cover property (done_ok && RD && ADDR == OFF_RESULT);

    c_standby:
    cover property (STANDBY && busy ##1 !STANDBY && busy);

endmodule
